// >>> shic_pkg.sv
package shic_pkg;
	// register byte offsets
	localparam logic [7:0] SHIC_MODE_SEL_OFS = 8'h00;
	localparam logic [7:0] SHIC_SAVE_CTRL_OFS = 8'h04;
	localparam logic [7:0] SHIC_CFG_OFS = 8'h08;
	localparam logic [7:0] SHIC_STAT_OFS = 8'h0C;
	// field positions
	localparam int SHIC_KIND_SEL_BIT = 0;
	localparam int SHIC_REQ_BIT = 1;
	localparam int SHIC_CFG_SUB_BIT = 0;
	localparam int SHIC_CFG_WT_MAIN_BIT = 1;
	localparam int SHIC_CFG_WDT2_MAIN_BIT = 2;
	// values after reset
	localparam logic SHIC_KIND_SEL_RST = 1'b0;
	localparam logic [2:0] SHIC_CFG_RST = 3'h0;
	localparam logic [7:0] SHIC_RDATA_RST = 8'h00;
	// operating mode
	typedef enum logic [1:0] {
		SHIC_NORMAL,
		SHIC_HALT,
		SHIC_IDLE
	} shic_mode_type;
endpackage

// >>> shic_wake_detect.sv
`timescale 1ns/100ps
module shic_wake_detect
	import shic_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_nmi,
	input wire logic [6:0] i_ext_irq,
	input wire logic [6:0] i_ext_mask,
	input wire logic i_periph_irq,
	input wire logic i_other_irq,
	input wire logic [2:0] i_req_prio,
	input wire logic i_in_service,
	input wire logic [2:0] i_service_prio,
	input wire logic i_irq_enabled,
	output logic o_wake_idle,
	output logic o_wake_halt,
	output logic o_take
);
	typedef struct packed {
		logic wake_idle;
		logic wake_halt;
		logic take;
	} shic_det_type;

	shic_det_type det_reg;
	shic_det_type det_next;
	logic maskable;

	////////////////////////////////////////////////////////////////
	// runs on the free system clock, never on a gated one, so wake events are seen in standby
	always_comb begin
		maskable = (|(i_ext_irq & ~i_ext_mask)) | i_periph_irq | i_other_irq;
		det_next = det_reg;
		det_next.wake_idle = i_nmi | (|(i_ext_irq & ~i_ext_mask)) | i_periph_irq;
		det_next.wake_halt = i_nmi | maskable;
		// lower level number is the higher priority; a lower request is left pending
		det_next.take = i_nmi | (maskable & i_irq_enabled &
			(~i_in_service | (i_req_prio < i_service_prio)));
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			det_reg <= '0;
		end else begin
			det_reg <= det_next;
		end
	end

	assign o_wake_idle = det_reg.wake_idle;
	assign o_wake_halt = det_reg.wake_halt;
	assign o_take = det_reg.take;
endmodule

// >>> shic_top.sv
// Functional notes
// - reset in HALT acts as ordinary reset
// - watch timer clock in HALT per selection
// - second watchdog clock in HALT per selection
// - port outputs held frozen during HALT
// - processor state and RAM retained in HALT
// - IDLE entered on stop request, select zero
// - IDLE gates processor and peripheral clocks
// - subclock and external-clock peripherals keep running
// - IDLE release resumes with no wait
// - IDLE wake on NMI, pins, peripherals, reset
// - IDLE release restores normal clocks
// - wake regardless of request priority
// - lower priority request wakes, stays pending
// - higher priority or NMI wakes and acknowledged
// - branch or continue after wake
// - halt instruction enters HALT
// - HALT stops processor clock, keeps peripheral clock
// - HALT ends on NMI, maskable, reset
`timescale 1ns/100ps
module shic_top
	import shic_pkg::*;
(
	input wire logic I_SYS_CLK,
	input wire logic I_RST_N,
	input wire logic [7:0] I_ADDR,
	input wire logic [7:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	input wire logic I_HALT_EXEC,
	input wire logic I_NMI,
	input wire logic [6:0] I_EXT_IRQ,
	input wire logic [6:0] I_EXT_MASK,
	input wire logic I_PERIPH_IRQ,
	input wire logic I_OTHER_IRQ,
	input wire logic [2:0] I_REQ_PRIO,
	input wire logic I_IN_SERVICE,
	input wire logic [2:0] I_SERVICE_PRIO,
	input wire logic I_IRQ_ENABLED,
	output logic [7:0] O_RDATA,
	output logic O_CPU_CLK_EN,
	output logic O_PERIPH_CLK_EN,
	output logic O_EXTCLK_PERIPH_EN,
	output logic O_WATCH_CLK_EN,
	output logic O_WDT2_CLK_EN,
	output logic O_PORT_HOLD,
	output logic O_RETAIN,
	output logic O_IRQ_ACK,
	output logic O_RESUME_NEXT,
	output logic [1:0] O_MODE
);
	typedef struct packed {
		shic_mode_type mode;
		logic kind_sel;
		logic [2:0] cfg;
		logic [7:0] rdata;
		logic cpu_en;
		logic periph_en;
		logic ext_en;
		logic watch_en;
		logic wdt2_en;
		logic hold;
		logic ack;
		logic resume;
	} shic_state_type;

	shic_state_type st_reg;
	shic_state_type st_next;
	logic wake_idle;
	logic wake_halt;
	logic take;
	logic sub_used;

	////////////////////////////////////////////////////////////////
	// wake detector on the ungated clock
	shic_wake_detect u_det (
		.i_clk(I_SYS_CLK),
		.i_rst_n(I_RST_N),
		.i_nmi(I_NMI),
		.i_ext_irq(I_EXT_IRQ),
		.i_ext_mask(I_EXT_MASK),
		.i_periph_irq(I_PERIPH_IRQ),
		.i_other_irq(I_OTHER_IRQ),
		.i_req_prio(I_REQ_PRIO),
		.i_in_service(I_IN_SERVICE),
		.i_service_prio(I_SERVICE_PRIO),
		.i_irq_enabled(I_IRQ_ENABLED),
		.o_wake_idle(wake_idle),
		.o_wake_halt(wake_halt),
		.o_take(take)
	);

	assign sub_used = st_reg.cfg[SHIC_CFG_SUB_BIT];

	////////////////////////////////////////////////////////////////
	// next state: registers, mode sequencing and clock enables
	always_comb begin
		st_next = st_reg;
		st_next.ack = 1'b0;
		st_next.resume = 1'b0;
		st_next.rdata = SHIC_RDATA_RST;
		// register writes
		if (I_WR) begin
			unique case (I_ADDR)
				SHIC_MODE_SEL_OFS: st_next.kind_sel = I_WDATA[SHIC_KIND_SEL_BIT];
				SHIC_CFG_OFS: st_next.cfg = I_WDATA[2:0];
				default: ;
			endcase
		end
		// read data appear one cycle after the strobe, zero elsewhere
		if (I_RD) begin
			unique case (I_ADDR)
				SHIC_MODE_SEL_OFS: st_next.rdata = {7'h00, st_reg.kind_sel};
				SHIC_CFG_OFS: st_next.rdata = {5'h00, st_reg.cfg};
				SHIC_STAT_OFS: st_next.rdata = {6'h00, st_reg.mode};
				default: st_next.rdata = SHIC_RDATA_RST;
			endcase
		end
		// mode sequencing; the stop request bit is a trigger and is not stored
		unique case (st_reg.mode)
			SHIC_NORMAL: begin
				if (I_WR && I_ADDR == SHIC_SAVE_CTRL_OFS && I_WDATA[SHIC_REQ_BIT] && !st_reg.kind_sel) begin
					st_next.mode = SHIC_IDLE;
				end else if (I_HALT_EXEC) begin
					st_next.mode = SHIC_HALT;
				end
			end
			SHIC_HALT: begin
				if (wake_halt) begin
					st_next.mode = SHIC_NORMAL;
				end
			end
			SHIC_IDLE: begin
				if (wake_idle) begin
					st_next.mode = SHIC_NORMAL;
				end
			end
		endcase
		// outcome of the wake: acknowledge and branch, or carry on with the next instruction
		if (st_reg.mode != SHIC_NORMAL && st_next.mode == SHIC_NORMAL) begin
			st_next.ack = take;
			st_next.resume = !take;
		end
		// enables follow the next mode so they flip in step with it
		st_next.cpu_en = (st_next.mode == SHIC_NORMAL);
		st_next.periph_en = (st_next.mode != SHIC_IDLE);
		st_next.ext_en = 1'b1;
		st_next.hold = (st_next.mode != SHIC_NORMAL);
		unique case (st_next.mode)
			SHIC_NORMAL: begin
				st_next.watch_en = 1'b1;
				st_next.wdt2_en = 1'b1;
			end
			SHIC_HALT: begin
				st_next.watch_en = st_next.cfg[SHIC_CFG_SUB_BIT] | st_next.cfg[SHIC_CFG_WT_MAIN_BIT];
				st_next.wdt2_en = st_next.cfg[SHIC_CFG_SUB_BIT] | st_next.cfg[SHIC_CFG_WDT2_MAIN_BIT];
			end
			SHIC_IDLE: begin
				st_next.watch_en = st_next.cfg[SHIC_CFG_SUB_BIT] | st_next.cfg[SHIC_CFG_WT_MAIN_BIT];
				// only a subclock-fed second watchdog survives IDLE
				st_next.wdt2_en = st_next.cfg[SHIC_CFG_SUB_BIT] & !st_next.cfg[SHIC_CFG_WDT2_MAIN_BIT];
			end
		endcase
	end

	////////////////////////////////////////////////////////////////
	// one register stage; enables are flop outputs so a gate cell never sees a glitch
	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			st_reg.mode <= SHIC_NORMAL;
			st_reg.kind_sel <= SHIC_KIND_SEL_RST;
			st_reg.cfg <= SHIC_CFG_RST;
			st_reg.rdata <= SHIC_RDATA_RST;
			st_reg.cpu_en <= 1'b1;
			st_reg.periph_en <= 1'b1;
			st_reg.ext_en <= 1'b1;
			st_reg.watch_en <= 1'b1;
			st_reg.wdt2_en <= 1'b1;
			st_reg.hold <= 1'b0;
			st_reg.ack <= 1'b0;
			st_reg.resume <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign O_RDATA = st_reg.rdata;
	assign O_CPU_CLK_EN = st_reg.cpu_en;
	assign O_PERIPH_CLK_EN = st_reg.periph_en;
	assign O_EXTCLK_PERIPH_EN = st_reg.ext_en;
	assign O_WATCH_CLK_EN = st_reg.watch_en;
	assign O_WDT2_CLK_EN = st_reg.wdt2_en;
	assign O_PORT_HOLD = st_reg.hold;
	assign O_RETAIN = st_reg.hold;
	assign O_IRQ_ACK = st_reg.ack;
	assign O_RESUME_NEXT = st_reg.resume;
	assign O_MODE = st_reg.mode;

	////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_RST_N);

	a_idle_entry_seq: assert property ((st_reg.mode == SHIC_NORMAL && I_WR && I_ADDR == SHIC_SAVE_CTRL_OFS
		&& I_WDATA[SHIC_REQ_BIT] && !st_reg.kind_sel) |=> st_reg.mode == SHIC_IDLE)
		else $error("idle not entered");
	a_idle_clocks_off: assert property (st_reg.mode == SHIC_IDLE |-> !O_CPU_CLK_EN && !O_PERIPH_CLK_EN
		&& O_EXTCLK_PERIPH_EN)
		else $error("idle clock gating wrong");
	a_halt_cpu_only: assert property (st_reg.mode == SHIC_HALT |-> !O_CPU_CLK_EN && O_PERIPH_CLK_EN)
		else $error("halt clock gating wrong");
	a_halt_entry_seq: assert property ((st_reg.mode == SHIC_NORMAL && I_HALT_EXEC && !I_WR)
		|=> st_reg.mode == SHIC_HALT)
		else $error("halt not entered");
	a_halt_wake_exit: assert property ((st_reg.mode == SHIC_HALT && wake_halt)
		|=> st_reg.mode == SHIC_NORMAL && O_CPU_CLK_EN)
		else $error("halt not released");
	a_idle_wake_fast: assert property ((st_reg.mode == SHIC_IDLE && wake_idle)
		|=> O_CPU_CLK_EN && O_PERIPH_CLK_EN)
		else $error("idle release delayed");
	a_port_hold_mode: assert property (O_PORT_HOLD == (st_reg.mode != SHIC_NORMAL))
		else $error("port hold mismatch");
	a_watch_halt_sel: assert property ((st_reg.mode == SHIC_HALT && !sub_used)
		|-> O_WATCH_CLK_EN == st_reg.cfg[SHIC_CFG_WT_MAIN_BIT])
		else $error("watch timer enable wrong");
	a_wdt2_halt_sel: assert property ((st_reg.mode == SHIC_HALT)
		|-> O_WDT2_CLK_EN == (sub_used | st_reg.cfg[SHIC_CFG_WDT2_MAIN_BIT]))
		else $error("watchdog enable wrong");
	a_lowprio_pending: assert property ((st_reg.mode != SHIC_NORMAL && wake_halt && wake_idle && !take)
		|=> !O_IRQ_ACK && O_RESUME_NEXT)
		else $error("low priority request acknowledged");
	a_wake_ack_once: assert property (O_IRQ_ACK |-> $past(st_reg.mode) != SHIC_NORMAL && !O_RESUME_NEXT)
		else $error("acknowledge outside wake");

	c_halt_round: cover property (st_reg.mode == SHIC_HALT ##1 st_reg.mode == SHIC_NORMAL);
	c_idle_round: cover property (st_reg.mode == SHIC_IDLE ##1 st_reg.mode == SHIC_NORMAL);
	c_wake_ack: cover property (O_IRQ_ACK);
	c_wake_resume: cover property (O_RESUME_NEXT);
endmodule

// >>> shic_top_bench.sv
`timescale 1ns/100ps
module shic_top_bench
	import shic_pkg::*;
;
	logic clk, rst_n, wr, rd, halt, nmi, pirq, oirq, insvc, irq_en;
	logic [7:0] addr, wdata, rdata;
	logic [6:0] ext, emask;
	logic [2:0] rprio, sprio, cv;
	logic cpu_en, per_en, ext_en, wt_en, wd_en, hold, ret, ack, nxt;
	logic [1:0] mode;
	logic [2:0] pr [5] = '{3'h5, 3'h1, 3'h3, 3'h1, 3'h5};
	logic [4:0] en = 5'b00111;
	logic [4:0] nm = 5'b10000;
	logic [4:0] tk = 5'b10010;
	int fail_count = 0;
	int comparisons = 0;
	int cycles = 0;
	shic_top dut (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
		.I_HALT_EXEC(halt), .I_NMI(nmi), .I_EXT_IRQ(ext), .I_EXT_MASK(emask), .I_PERIPH_IRQ(pirq),
		.I_OTHER_IRQ(oirq), .I_REQ_PRIO(rprio), .I_IN_SERVICE(insvc), .I_SERVICE_PRIO(sprio),
		.I_IRQ_ENABLED(irq_en), .O_RDATA(rdata), .O_CPU_CLK_EN(cpu_en), .O_PERIPH_CLK_EN(per_en),
		.O_EXTCLK_PERIPH_EN(ext_en), .O_WATCH_CLK_EN(wt_en), .O_WDT2_CLK_EN(wd_en), .O_PORT_HOLD(hold),
		.O_RETAIN(ret), .O_IRQ_ACK(ack), .O_RESUME_NEXT(nxt), .O_MODE(mode));
	////////////////////////////////////////////////////////////////
	// compare helpers; four-state compare so an unknown never matches
	task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic [11:0] st();
		return {3'h0, mode, cpu_en, per_en, ext_en, wt_en, wd_en, hold, ret};
	endfunction
	// expected outputs: cpu runs and ports float only in normal mode
	function automatic logic [11:0] es(logic [1:0] m, logic per, logic wt, logic wd);
		return {3'h0, m, m == 2'h0, per, 1'b1, wt, wd, m != 2'h0, m != 2'h0};
	endfunction
	////////////////////////////////////////////////////////////////
	// bus and event drivers; one idle edge between calls keeps strobes clean
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk("rdata", {4'h0, e}, {4'h0, rdata});
	endtask
	task automatic halt_pulse();
		@(posedge clk);
		halt <= 1'b1;
		@(posedge clk);
		halt <= 1'b0;
		#1;
	endtask
	// wake latency is fixed at two edges, pulse lasts exactly one cycle
	task automatic wake(input logic n, input logic [6:0] e, input logic p, input logic [1:0] pulses);
		@(posedge clk);
		nmi <= n;
		ext <= e;
		pirq <= p;
		repeat (2) @(posedge clk);
		#1 chk("wake", {8'h0, 2'h0, pulses}, {8'h0, mode, ack, nxt});
		@(posedge clk);
		nmi <= 1'b0;
		ext <= 7'h00;
		pirq <= 1'b0;
		#1 chk("pulse end", 12'h000, {10'h0, ack, nxt});
	endtask
	task automatic tally_and_finish();
		if (fail_count == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// clock and hang guard; the full run needs well under a thousand cycles
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		{rst_n, wr, rd, halt, nmi, pirq, oirq, insvc, irq_en} = 9'h001;
		{addr, wdata, ext, emask, rprio, sprio, cv} = '0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		#1 chk("reset state", es(2'h0, 1'b1, 1'b1, 1'b1), st());
		rd_chk(SHIC_CFG_OFS, 8'h00);
		rd_chk(8'hFF, 8'h00);
		wr_reg(SHIC_STAT_OFS, 8'h02);
		rd_chk(SHIC_STAT_OFS, 8'h00);
		wr_reg(SHIC_MODE_SEL_OFS, 8'h01);
		rd_chk(SHIC_MODE_SEL_OFS, 8'h01);
		wr_reg(SHIC_SAVE_CTRL_OFS, 8'h02);
		chk("kind select set", es(2'h0, 1'b1, 1'b1, 1'b1), st());
		wr_reg(SHIC_MODE_SEL_OFS, 8'h00);
		// every clock selection through both standby modes
		for (int c = 0; c < 8; c++) begin
			cv = 3'(c);
			wr_reg(SHIC_CFG_OFS, 8'(c));
			rd_chk(SHIC_CFG_OFS, 8'(c));
			halt_pulse();
			chk("halt", es(2'h1, 1'b1, cv[0] | cv[1], cv[0] | cv[2]), st());
			halt_pulse();
			chk("halt again", es(2'h1, 1'b1, cv[0] | cv[1], cv[0] | cv[2]), st());
			wake(1'b1, 7'h00, 1'b0, 2'b10);
			chk("after halt", es(2'h0, 1'b1, 1'b1, 1'b1), st());
			wr_reg(SHIC_SAVE_CTRL_OFS, 8'h02);
			chk("idle", es(2'h2, 1'b0, cv[0] | cv[1], cv[0] & ~cv[2]), st());
			// masked pins and non-idle peripherals must not wake idle
			@(posedge clk);
			ext <= 7'h7F;
			emask <= 7'h7F;
			oirq <= 1'b1;
			repeat (4) @(posedge clk);
			ext <= 7'h00;
			emask <= 7'h00;
			oirq <= 1'b0;
			#1 chk("masked", {8'h0, 2'h2, 2'b00}, {8'h0, mode, ack, nxt});
			wake(c % 3 == 0, (c % 3 == 1) ? 7'(7'h01 << (c % 7)) : 7'h00, c % 3 == 2, 2'b10);
			chk("after idle", es(2'h0, 1'b1, 1'b1, 1'b1), st());
		end
		wake(1'b1, 7'h00, 1'b0, 2'b00);
		// idle entered from a service routine at level 3
		@(posedge clk);
		insvc <= 1'b1;
		sprio <= 3'h3;
		for (int k = 0; k < 5; k++) begin
			wr_reg(SHIC_SAVE_CTRL_OFS, 8'h02);
			@(posedge clk);
			rprio <= pr[k];
			irq_en <= en[k];
			wake(nm[k], 7'h00, ~nm[k], {tk[k], ~tk[k]});
		end
		// reset while halted behaves as a plain reset
		halt_pulse();
		@(posedge clk);
		rst_n <= 1'b0;
		#1 chk("reset in halt", es(2'h0, 1'b1, 1'b1, 1'b1), st());
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd_chk(SHIC_CFG_OFS, 8'h00);
		tally_and_finish();
	end
endmodule
